// ===== estp_pkg.sv
// Purpose: Shared constants of the event driven timer/PWM unit
// Assumes: APB byte addresses, 32-bit data, one aligned word per register
// Notes:   Array registers sit in 64-byte groups of sixteen words
package estp_pkg;
   // Single registers
   localparam logic [11:0] A_CFG     = 12'h000;
   localparam logic [11:0] A_CTRL    = 12'h004;
   localparam logic [11:0] A_COUNT   = 12'h008;
   localparam logic [11:0] A_STATE   = 12'h00C;
   localparam logic [11:0] A_OUTPUT  = 12'h010;
   localparam logic [11:0] A_FLAG    = 12'h014;
   localparam logic [11:0] A_MASK    = 12'h018;
   localparam logic [11:0] A_DMAEN   = 12'h01C;
   localparam logic [11:0] A_REGMODE = 12'h020;
   localparam logic [11:0] A_INPUT   = 12'h024;
   // Array groups, selected by paddr[11:6], entry by paddr[5:2]
   localparam logic [5:0]  G_MATCH   = 6'h04;
   localparam logic [5:0]  G_CAPSEL  = 6'h05;
   localparam logic [5:0]  G_EVCTRL  = 6'h06;
   localparam logic [5:0]  G_EVSTATE = 6'h07;
   localparam logic [5:0]  G_OUTSET  = 6'h08;
   localparam logic [5:0]  G_OUTCLR  = 6'h09;
   // Configuration fields
   localparam int CFG_UNIFY   = 0;
   localparam int CFG_CKIN    = 1;
   localparam int CFG_CKSEL   = 2;
   localparam int CFG_AUTOLIM = 5;
   localparam int CFG_BIDIR   = 7;
   // Control fields, per half: stop at 2h, halt at 2h+1
   localparam int CTRL_STOP   = 0;
   localparam int CTRL_HALT   = 1;
   localparam logic [3:0] CTRL_RST = 4'hA;
   // Event control fields
   localparam int EV_MSEL   = 0;
   localparam int EV_HSEL   = 4;
   localparam int EV_OUTSEL = 5;
   localparam int EV_IOSEL  = 6;
   localparam int EV_IOCOND = 10;
   localparam int EV_COMB   = 12;
   localparam int EV_STLD   = 14;
   localparam int EV_STV    = 15;
   localparam int EV_HOLD   = 20;
   localparam int EV_DIRQ   = 21;
   localparam int EV_START  = 23;
   localparam int EV_STOP   = 24;
   localparam int EV_HALT   = 25;
   localparam int EV_LIMIT  = 26;
   // Encodings
   localparam logic [1:0] COND_LOW   = 2'h0;
   localparam logic [1:0] COND_RISE  = 2'h1;
   localparam logic [1:0] COND_FALL  = 2'h2;
   localparam logic [1:0] COND_HIGH  = 2'h3;
   localparam logic [1:0] COMB_OR    = 2'h0;
   localparam logic [1:0] COMB_MATCH = 2'h1;
   localparam logic [1:0] COMB_IO    = 2'h2;
   localparam logic [1:0] COMB_AND   = 2'h3;
   localparam logic [1:0] DIRQ_ANY   = 2'h0;
   localparam logic [1:0] DIRQ_UP    = 2'h1;
   localparam logic [1:0] DIRQ_DOWN  = 2'h2;
endpackage

// ===== estp_event.sv
// Purpose: Condition evaluator of one event
// Assumes: All inputs except in_now are registered state of the parent
// Notes:   Purely combinational; the parent holds the pending flag
`timescale 1ns/100ps
module estp_event #(
   parameter int NUM_MATCH = 16,
   parameter int NUM_IN    = 8,
   parameter int NUM_OUT   = 10
) (
   input  wire logic [31:0]          ev_ctrl,
   input  wire logic [31:0]          state_mask,
   input  wire logic [4:0]           state,
   input  wire logic [NUM_MATCH-1:0] match_lo,
   input  wire logic [NUM_MATCH-1:0] match_hi,
   input  wire logic [NUM_IN-1:0]    in_now,
   input  wire logic [NUM_IN-1:0]    in_prev,
   input  wire logic [NUM_OUT-1:0]   out_now,
   input  wire logic [NUM_OUT-1:0]   out_prev,
   input  wire logic [1:0]           dir_down,
   input  wire logic                 unify,
   input  wire logic                 pending,
   output logic                      fire,
   output logic                      match_hit
);
   if (NUM_MATCH > 16 || NUM_IN > 16 || NUM_OUT > 16) begin : g_bad
      $error("estp_event: more than sixteen matches, inputs or outputs");
   end

   logic       hsel;
   logic       cur;
   logic       prv;
   logic       io_ok;
   logic       base;
   logic       dir_ok;
   logic [3:0] msel;
   logic [3:0] iosel;

   always_comb begin
      hsel = ev_ctrl[estp_pkg::EV_HSEL] & ~unify;
      msel = ev_ctrl[estp_pkg::EV_MSEL +: 4];
      iosel = ev_ctrl[estp_pkg::EV_IOSEL +: 4];
      match_hit = 1'b0;
      cur = 1'b0;
      prv = 1'b0;
      for (int i = 0; i < NUM_MATCH; i++) begin
         if (msel == 4'(i)) begin
            match_hit = hsel ? match_hi[i] : match_lo[i];
         end
      end
      if (ev_ctrl[estp_pkg::EV_OUTSEL]) begin
         for (int i = 0; i < NUM_OUT; i++) begin
            if (iosel == 4'(i)) begin
               cur = out_now[i];
               prv = out_prev[i];
            end
         end
      end else begin
         for (int i = 0; i < NUM_IN; i++) begin
            if (iosel == 4'(i)) begin
               cur = in_now[i];
               prv = in_prev[i];
            end
         end
      end
      case (ev_ctrl[estp_pkg::EV_IOCOND +: 2])
         estp_pkg::COND_LOW:  io_ok = ~cur;
         estp_pkg::COND_RISE: io_ok = cur & ~prv;
         estp_pkg::COND_FALL: io_ok = ~cur & prv;
         default:             io_ok = cur;
      endcase
      case (ev_ctrl[estp_pkg::EV_COMB +: 2])
         estp_pkg::COMB_OR:    base = match_hit | io_ok;
         estp_pkg::COMB_MATCH: base = match_hit;
         estp_pkg::COMB_IO:    base = io_ok;
         default:              base = match_hit & io_ok;
      endcase
      // A held match waits for the I/O condition to qualify it
      if (ev_ctrl[estp_pkg::EV_HOLD]) begin
         base = (match_hit | pending) & io_ok;
      end
      case (ev_ctrl[estp_pkg::EV_DIRQ +: 2])
         estp_pkg::DIRQ_UP:   dir_ok = ~dir_down[hsel];
         estp_pkg::DIRQ_DOWN: dir_ok = dir_down[hsel];
         default:             dir_ok = 1'b1;
      endcase
      fire = base & dir_ok & state_mask[state];
   end
endmodule

// ===== estp_top.sv
// Purpose: Event driven timer/PWM unit with an APB register slave
// Assumes: Inputs synchronous to pclk; zero wait state APB
// Notes:   Outputs, captures and state change only on events or software writes
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
// Overview of operation
// - The counter is one 32-bit counter or two 16-bit halves, each counting up only or up and down.
// - Each counter advances on every clock or on rising edges of one selected input.
// - Each of the sixteen match/capture registers is chosen as match or capture.
// - An event is a match, an input/output edge or level, or a combination of them.
// - Every action except counting and the match zero limit happens only when an enabled event fires.
// - An event may start, stop or halt a counter.
// - A limit clears a one-way counter and reverses a two-way counter.
// - An event may set, clear or toggle any output.
// - A selected event copies the counter into a capture register.
// - Events may raise the interrupt, request DMA and change the state.
// - Match register zero may serve as the counter limit on its own.
// - In two-way mode an event may be qualified by the count direction.
// - A match may be held pending until a qualifying event arrives.
// - Each event is enabled in a set of the 32 states and may load a new state.
// - The state persists across counter periods.
// - Up to ten outputs carry PWM with own duty; the period is common with one 32-bit counter and set per half with two halves.
module estp_top #(
   parameter int NUM_MATCH = 16,
   parameter int NUM_EV    = 16,
   parameter int NUM_IN    = 8,
   parameter int NUM_OUT   = 10
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   input  wire logic [NUM_IN-1:0]  ev_in,
   output logic [NUM_OUT-1:0]      ev_out,
   output logic                    irq,
   output logic                    dma_req
);
   if (NUM_MATCH > 16 || NUM_EV > 16 || NUM_IN > 8 || NUM_OUT > 16 || NUM_MATCH < 1) begin : g_bad
      $error("estp_top: parameter out of the range the register map serves");
   end

   typedef struct packed {
      logic [31:0]                       cfg;
      logic [3:0]                        ctrl;
      logic [1:0][15:0]                  cnt;
      logic [1:0]                        dir;
      logic [4:0]                        state;
      logic [NUM_OUT-1:0]                out;
      logic [NUM_OUT-1:0]                out_prev;
      logic [NUM_IN-1:0]                 in_prev;
      logic [NUM_EV-1:0]                 flag;
      logic [NUM_EV-1:0]                 mask;
      logic [NUM_EV-1:0]                 dmaen;
      logic [NUM_EV-1:0]                 pend;
      logic [NUM_MATCH-1:0]              regmode;
      logic [NUM_MATCH-1:0][31:0]        match;
      logic [NUM_MATCH-1:0][NUM_EV-1:0]  capsel;
      logic [NUM_EV-1:0][31:0]           evctrl;
      logic [NUM_EV-1:0][31:0]           evstate;
      logic [NUM_OUT-1:0][NUM_EV-1:0]    outset;
      logic [NUM_OUT-1:0][NUM_EV-1:0]    outclr;
      logic                              dma;
      logic [31:0]                       rdata;
   } estp_state_t;

   estp_state_t          q;
   estp_state_t          d;
   logic [NUM_MATCH-1:0] mat_lo;
   logic [NUM_MATCH-1:0] mat_hi;
   logic [NUM_EV-1:0]    fire;
   logic [NUM_EV-1:0]    mhit;
   logic [31:0]          cnt32;
   logic                 hit;

   // Up/down step; bit 32 of the result is the new down flag
   function automatic logic [32:0] estp_step(input logic [31:0] v, input logic down,
                                             input logic bidir, input logic lim);
      logic [31:0] r;
      logic        nd;
      r = v + 32'h0000_0001;
      nd = down;
      if (!bidir) begin
         if (lim) begin
            r = 32'h0000_0000;
         end
      end else if (down) begin
         if (v == 32'h0000_0000) begin
            nd = 1'b0;
         end else begin
            r = v - 32'h0000_0001;
         end
      end else if (lim) begin
         nd = 1'b1;
         r = v - 32'h0000_0001;
      end
      return {nd, r};
   endfunction

   assign cnt32 = {q.cnt[1], q.cnt[0]};

   always_comb begin
      for (int i = 0; i < NUM_MATCH; i++) begin
         mat_lo[i] = q.cfg[estp_pkg::CFG_UNIFY] ? (cnt32 == q.match[i]) : (q.cnt[0] == q.match[i][15:0]);
         mat_hi[i] = q.cnt[1] == q.match[i][31:16];
      end
   end

   // Capture entries are masked out so a stored count never raises a match
   for (genvar j = 0; j < NUM_EV; j++) begin : g_ev
      estp_event #(
         .NUM_MATCH (NUM_MATCH),
         .NUM_IN    (NUM_IN),
         .NUM_OUT   (NUM_OUT)
      ) u_ev (
         .ev_ctrl    (q.evctrl[j]),
         .state_mask (q.evstate[j]),
         .state      (q.state),
         .match_lo   (mat_lo & ~q.regmode),
         .match_hi   (mat_hi & ~q.regmode),
         .in_now     (ev_in),
         .in_prev    (q.in_prev),
         .out_now    (q.out),
         .out_prev   (q.out_prev),
         .dir_down   (q.dir),
         .unify      (q.cfg[estp_pkg::CFG_UNIFY]),
         .pending    (q.pend[j]),
         .fire       (fire[j]),
         .match_hit  (mhit[j])
      );
   end

   // Decode for both unmapped-address error and read mux
   always_comb begin
      case (paddr[11:6])
         6'h00:                hit = paddr[5:2] <= 4'h9;
         estp_pkg::G_MATCH,
         estp_pkg::G_CAPSEL:   hit = 32'(paddr[5:2]) < NUM_MATCH;
         estp_pkg::G_EVCTRL,
         estp_pkg::G_EVSTATE:  hit = 32'(paddr[5:2]) < NUM_EV;
         estp_pkg::G_OUTSET,
         estp_pkg::G_OUTCLR:   hit = 32'(paddr[5:2]) < NUM_OUT;
         default:              hit = 1'b0;
      endcase
      hit = hit & (paddr[1:0] == 2'h0);
   end

   always_comb begin
      logic [1:0]  start_h;
      logic [1:0]  stop_h;
      logic [1:0]  halt_h;
      logic [1:0]  lim_h;
      logic        tick;
      logic        uni;
      logic        h;
      logic        s;
      logic        c;
      logic        wr;
      logic [3:0]  k;
      logic [32:0] st;
      logic [2:0]  cksel;
      start_h = 2'h0;
      stop_h = 2'h0;
      halt_h = 2'h0;
      lim_h = 2'h0;
      tick = 1'b0;
      h = 1'b0;
      s = 1'b0;
      c = 1'b0;
      st = 33'h0_0000_0000;
      d = q;
      uni = q.cfg[estp_pkg::CFG_UNIFY];
      wr = psel & penable & pwrite & hit;
      k = paddr[5:2];
      cksel = q.cfg[estp_pkg::CFG_CKSEL +: 3];
      d.in_prev = ev_in;
      d.out_prev = q.out;

      // Event actions gathered per counter half
      for (int j = 0; j < NUM_EV; j++) begin
         h = q.evctrl[j][estp_pkg::EV_HSEL] & ~uni;
         if (fire[j]) begin
            start_h[h] = start_h[h] | q.evctrl[j][estp_pkg::EV_START];
            stop_h[h] = stop_h[h] | q.evctrl[j][estp_pkg::EV_STOP];
            halt_h[h] = halt_h[h] | q.evctrl[j][estp_pkg::EV_HALT];
            lim_h[h] = lim_h[h] | q.evctrl[j][estp_pkg::EV_LIMIT];
            if (q.evctrl[j][estp_pkg::EV_STLD]) begin
               d.state = q.evctrl[j][estp_pkg::EV_STV +: 5];
            end
         end
         // Pending match survives until its event fires
         d.pend[j] = (q.pend[j] | (mhit[j] & q.evctrl[j][estp_pkg::EV_HOLD])) & ~fire[j];
      end
      lim_h[0] = lim_h[0] | (q.cfg[estp_pkg::CFG_AUTOLIM] & mat_lo[0] & ~q.regmode[0]);
      lim_h[1] = lim_h[1] | (q.cfg[estp_pkg::CFG_AUTOLIM + 1] & mat_hi[0] & ~q.regmode[0]);

      // Count source: every clock or rising edge of one input
      if (q.cfg[estp_pkg::CFG_CKIN]) begin
         for (int i = 0; i < NUM_IN; i++) begin
            if (cksel == 3'(i)) begin
               tick = ev_in[i] & ~q.in_prev[i];
            end
         end
      end else begin
         tick = 1'b1;
      end

      if (uni) begin
         if (tick && !q.ctrl[estp_pkg::CTRL_STOP] && !q.ctrl[estp_pkg::CTRL_HALT]) begin
            st = estp_step(cnt32, q.dir[0], q.cfg[estp_pkg::CFG_BIDIR], lim_h[0]);
            d.cnt[1] = st[31:16];
            d.cnt[0] = st[15:0];
            d.dir[0] = st[32];
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (tick && !q.ctrl[2*i+estp_pkg::CTRL_STOP] && !q.ctrl[2*i+estp_pkg::CTRL_HALT]) begin
               st = estp_step({16'h0000, q.cnt[i]}, q.dir[i], q.cfg[estp_pkg::CFG_BIDIR + i], lim_h[i]);
               d.cnt[i] = st[15:0];
               d.dir[i] = st[32];
            end
         end
      end

      // Captures take the whole count, both halves
      for (int i = 0; i < NUM_MATCH; i++) begin
         if (q.regmode[i] && |(q.capsel[i] & fire)) begin
            d.match[i] = cnt32;
         end
      end

      // Both set and clear in one cycle toggles, so the result never depends on event order
      for (int o = 0; o < NUM_OUT; o++) begin
         s = |(q.outset[o] & fire);
         c = |(q.outclr[o] & fire);
         if (s && c) begin
            d.out[o] = ~q.out[o];
         end else if (s) begin
            d.out[o] = 1'b1;
         end else if (c) begin
            d.out[o] = 1'b0;
         end
      end

      d.dma = |(fire & q.dmaen);

      // Software writes; counter, state and outputs are loaded over the events
      if (wr) begin
         case (paddr[11:6])
            6'h00: begin
               case ({paddr[11:2], 2'h0})
                  estp_pkg::A_CFG:     d.cfg = pwdata;
                  estp_pkg::A_CTRL:    d.ctrl = pwdata[3:0];
                  estp_pkg::A_COUNT:   {d.cnt[1], d.cnt[0]} = pwdata;
                  estp_pkg::A_STATE:   d.state = pwdata[4:0];
                  estp_pkg::A_OUTPUT:  d.out = pwdata[NUM_OUT-1:0];
                  estp_pkg::A_MASK:    d.mask = pwdata[NUM_EV-1:0];
                  estp_pkg::A_DMAEN:   d.dmaen = pwdata[NUM_EV-1:0];
                  estp_pkg::A_REGMODE: d.regmode = pwdata[NUM_MATCH-1:0];
                  default:             d.cfg = q.cfg;
               endcase
            end
            estp_pkg::G_MATCH:   d.match[k] = pwdata;
            estp_pkg::G_CAPSEL:  d.capsel[k] = pwdata[NUM_EV-1:0];
            estp_pkg::G_EVCTRL:  d.evctrl[k] = pwdata;
            estp_pkg::G_EVSTATE: d.evstate[k] = pwdata;
            estp_pkg::G_OUTSET:  d.outset[k] = pwdata[NUM_EV-1:0];
            estp_pkg::G_OUTCLR:  d.outclr[k] = pwdata[NUM_EV-1:0];
            default:             d.cfg = d.cfg;
         endcase
      end

      // Event driven counter control wins over a control write in the same cycle
      for (int i = 0; i < 2; i++) begin
         if (stop_h[i]) begin
            d.ctrl[2*i+estp_pkg::CTRL_STOP] = 1'b1;
         end else if (start_h[i]) begin
            d.ctrl[2*i+estp_pkg::CTRL_STOP] = 1'b0;
         end
         if (halt_h[i]) begin
            d.ctrl[2*i+estp_pkg::CTRL_HALT] = 1'b1;
         end
      end

      // Sticky flags: an event in the clearing cycle is kept
      d.flag = (wr && {paddr[11:2], 2'h0} == estp_pkg::A_FLAG) ? (q.flag & ~pwdata[NUM_EV-1:0]) : q.flag;
      d.flag = d.flag | fire;

      // Read data is latched in the setup phase for the access phase
      d.rdata = 32'h0000_0000;
      if (psel && !penable && !pwrite && hit) begin
         case (paddr[11:6])
            6'h00: begin
               case ({paddr[11:2], 2'h0})
                  estp_pkg::A_CFG:     d.rdata = q.cfg;
                  estp_pkg::A_CTRL:    d.rdata = 32'(q.ctrl);
                  estp_pkg::A_COUNT:   d.rdata = cnt32;
                  estp_pkg::A_STATE:   d.rdata = 32'(q.state);
                  estp_pkg::A_OUTPUT:  d.rdata = 32'(q.out);
                  estp_pkg::A_FLAG:    d.rdata = 32'(q.flag);
                  estp_pkg::A_MASK:    d.rdata = 32'(q.mask);
                  estp_pkg::A_DMAEN:   d.rdata = 32'(q.dmaen);
                  estp_pkg::A_REGMODE: d.rdata = 32'(q.regmode);
                  estp_pkg::A_INPUT:   d.rdata = 32'(ev_in);
                  default:             d.rdata = 32'h0000_0000;
               endcase
            end
            estp_pkg::G_MATCH:   d.rdata = q.match[k];
            estp_pkg::G_CAPSEL:  d.rdata = 32'(q.capsel[k]);
            estp_pkg::G_EVCTRL:  d.rdata = q.evctrl[k];
            estp_pkg::G_EVSTATE: d.rdata = q.evstate[k];
            estp_pkg::G_OUTSET:  d.rdata = 32'(q.outset[k]);
            estp_pkg::G_OUTCLR:  d.rdata = 32'(q.outclr[k]);
            default:             d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // Both halves come out of reset halted, so nothing counts before the events are set up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.ctrl <= estp_pkg::CTRL_RST;
      end else begin
         q <= d;
      end
   end

   // No wait states: a master never stalls on this slave
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;
   assign prdata  = q.rdata;
   assign ev_out  = q.out;
   assign irq     = |(q.flag & q.mask);
   assign dma_req = q.dma;
endmodule

// ===== estp_props.sv
// Purpose: Port level checks of the event timer/PWM unit
// Assumes: Zero wait state APB as handed over
// Notes:   Only top ports are visible here
`timescale 1ns/100ps
module estp_props #(
   parameter int NUM_IN  = 8,
   parameter int NUM_OUT = 10
) (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [11:0]        paddr,
   input wire logic [31:0]        pwdata,
   input wire logic               pready,
   input wire logic [31:0]        prdata,
   input wire logic               pslverr,
   input wire logic [NUM_IN-1:0]  ev_in,
   input wire logic [NUM_OUT-1:0] ev_out,
   input wire logic               irq,
   input wire logic               dma_req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_acc;
      psel && penable;
   endsequence
   sequence s_wr(logic [11:0] a);
      s_acc ##0 pwrite && paddr == a;
   endsequence
   AST_READY: assert property (s_acc |-> pready) else $error("access not completed");
   AST_IDLE_RD: assert property (!(psel && penable) |-> prdata == 32'h0) else $error("stray read data");
   AST_WR_RD: assert property (s_acc ##0 pwrite |-> prdata == 32'h0) else $error("read data on write");
   AST_MISALIGN: assert property (s_acc ##0 paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0) else $error("bad align");
   AST_MAPPED: assert property (s_acc ##0 paddr == estp_pkg::A_CFG |-> !pslverr) else $error("mapped refused");
   AST_STATE_RSV: assert property (s_acc ##0 !pwrite && paddr == estp_pkg::A_STATE |->
      prdata[31:5] == 27'h0) else $error("state reserved bits");
   AST_OUT_WR: assert property (s_wr(estp_pkg::A_OUTPUT) |=> ev_out == $past(pwdata[NUM_OUT-1:0]))
      else $error("output write lost");
   AST_MASK_OFF: assert property (s_wr(estp_pkg::A_MASK) ##0 pwdata == 32'h0 |=> !irq)
      else $error("masked irq");
   AST_DMA_OFF: assert property (s_wr(estp_pkg::A_DMAEN) ##0 pwdata == 32'h0 |=> ##1 !dma_req)
      else $error("dma after disable");
endmodule
bind estp_top estp_props #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) u_estp_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .ev_in(ev_in), .ev_out(ev_out),
   .irq(irq), .dma_req(dma_req));

// ===== estp_pins.sv
// Purpose: External pin model driving the event inputs
// Assumes: Pins are synchronous to pclk
// Notes:   A request raises pin 0 for two cycles
`timescale 1ns/100ps
module estp_pins (
   input  wire logic       pclk,
   input  wire logic       pulse,
   output logic [7:0]      pins
);
   initial pins = 8'h00;
   always @(posedge pclk) begin
      if (pulse) begin
         pins[0] <= 1'b1;
         @(posedge pclk);
         @(posedge pclk);
         pins[0] <= 1'b0;
      end
   end
endmodule

// ===== test_event_state_timer_pwm.sv
// Purpose: Self checking bench of the event timer/PWM unit
// Assumes: APB master of the bench, pin model on ev_in
// Notes:   Reads queue their expectation for the monitor
`timescale 1ns/100ps
module test_event_state_timer_pwm;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pulse = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rnd = 32'hC4DC6ECC, exp_q[$];
   logic        pready, pslverr, irq, dma_req;
   logic [31:0] prdata;
   logic [7:0]  ev_in;
   logic [9:0]  ev_out;
   int          num_errors = 0, samples_checked = 0, cyc = 0, hi, dm;
   always #5 pclk = ~pclk;
   estp_top u_estp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .ev_in(ev_in),
      .ev_out(ev_out), .irq(irq), .dma_req(dma_req));
   estp_pins u_estp_pins (.pclk(pclk), .pulse(pulse), .pins(ev_in));
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   function automatic logic [11:0] ga(input logic [5:0] g, input int i);
      return {g, i[3:0], 2'b00};
   endfunction
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic wrap_up();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready) begin
         if (prdata !== exp_q[0]) begin
            num_errors++;
            $display("BAD %0t read %h got %h", $time, paddr, prdata);
         end
         samples_checked++;
         void'(exp_q.pop_front());
      end
      cyc++;
      if (cyc > 5000) begin
         num_errors++;
         wrap_up();
      end
   end
   initial begin
      logic [11:0] a[15];
      logic [31:0] d[15];
      a = '{ga(6'h04, 0), ga(6'h04, 1), ga(6'h06, 0), ga(6'h06, 1), ga(6'h07, 0), ga(6'h07, 1), ga(6'h08, 0),
         ga(6'h09, 0), estp_pkg::A_REGMODE, ga(6'h05, 2), estp_pkg::A_DMAEN, ga(6'h06, 2), ga(6'h07, 2),
         estp_pkg::A_CFG, estp_pkg::A_CTRL};
      // Period ten from the limit, set at the limit, clear at count four, pin rise loads state 3
      d = '{32'h9, 32'h4, 32'h1000, 32'h1001, 32'h1, 32'h1, 32'h1, 32'h2, 32'h4, 32'h1, 32'h1, 32'h1E400,
         32'h1, 32'h21, 32'h0};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(ev_out === 10'h0 && irq === 1'b0 && dma_req === 1'b0, "reset outputs");
      rd(estp_pkg::A_CTRL, 32'hA);
      rnd = xs(rnd);
      apb(1'b1, ga(6'h04, 5), rnd);
      rd(ga(6'h04, 5), rnd);
      for (int i = 0; i < 15; i++) apb(1'b1, a[i], d[i]);
      repeat (12) @(posedge pclk);
      hi = 0;
      dm = 0;
      repeat (20) @(posedge pclk) begin
         hi += int'(ev_out[0] === 1'b1);
         dm += int'(dma_req === 1'b1);
      end
      chk(hi == 10, "pwm duty");
      chk(dm == 2, "dma pulses");
      apb(1'b1, estp_pkg::A_MASK, 32'h1);
      @(negedge pclk);
      chk(irq === 1'b1, "irq raised");
      rd(ga(6'h04, 2), 32'h9);
      rd(estp_pkg::A_STATE, 32'h0);
      pulse <= 1'b1;
      @(posedge pclk);
      pulse <= 1'b0;
      repeat (4) @(posedge pclk);
      rd(estp_pkg::A_STATE, 32'h3);
      hi = 0;
      repeat (20) @(posedge pclk) hi += int'(ev_out[0] === 1'b1);
      chk(hi == 0 || hi == 20, "events gated by state");
      apb(1'b1, estp_pkg::A_OUTPUT, 32'h3FF);
      repeat (15) @(posedge pclk);
      chk(ev_out === 10'h3FF, "outputs hold");
      apb(1'b1, estp_pkg::A_CTRL, 32'hA);
      apb(1'b1, estp_pkg::A_COUNT, 32'h5);
      rd(estp_pkg::A_COUNT, 32'h5);
      apb(1'b1, estp_pkg::A_DMAEN, 32'h0);
      apb(1'b1, estp_pkg::A_FLAG, 32'hFFFF);
      rd(estp_pkg::A_FLAG, 32'h0);
      chk(irq === 1'b0, "irq cleared");
      apb(1'b1, estp_pkg::A_MASK, 32'h0);
      // Two-way count to the limit of nine; event 1 clears output 0 at count four going down only
      apb(1'b1, ga(6'h06, 1), 32'h401001);
      apb(1'b1, ga(6'h07, 1), 32'h8);
      apb(1'b1, estp_pkg::A_CFG, 32'hA1);
      apb(1'b1, estp_pkg::A_COUNT, 32'h0);
      apb(1'b1, estp_pkg::A_CTRL, 32'h0);
      repeat (12) @(posedge pclk);
      @(negedge pclk);
      chk(ev_out[0] === 1'b1, "up pass ignored");
      rd(estp_pkg::A_COUNT, 32'h5);
      @(negedge pclk);
      chk(ev_out[0] === 1'b0, "down pass clears");
      rd(12'h002, 32'h0);
      rd(12'h3FC, 32'h0);
      @(posedge pclk);
      wrap_up();
   end
endmodule
